/* File: aenpr_map.svh */
`ifndef AENPR_MAP_SVH
`define AENPR_MAP_SVH

// Management register offsets
`define AENPR_OFF_EXP      5'h06
`define AENPR_OFF_NPTX     5'h07

// Expansion status field positions
`define AENPR_EXP_LPAN     0
`define AENPR_EXP_PGRX     1
`define AENPR_EXP_NPABLE   2
`define AENPR_EXP_LPNP     3
`define AENPR_EXP_PDFLT    4
`define AENPR_EXP_CW_LO    5
`define AENPR_EXP_CW_HI    15

// Next-page transmit field positions
`define AENPR_NP_CODE_LO   0
`define AENPR_NP_CODE_HI   10
`define AENPR_NP_TOGGLE    11
`define AENPR_NP_SECOND_ACKNOWLEDGE      12
`define AENPR_NP_MSGPG     13
`define AENPR_NP_RSV       14
`define AENPR_NP_NEXT      15

// Reset values
`define AENPR_NPTX_RST     16'h2001
`define AENPR_CW_RST       11'h000
`define AENPR_NPABLE_VAL   1'h1

`endif

/* File: aenpr_pkg.sv */
`default_nettype none

package aenpr_pkg;

   // Next-page exchange sequencing, one-hot
   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h1,
      SEQ_BASE = 4'h2,
      SEQ_NEXT = 4'h4,
      SEQ_DONE = 4'h8
   } aenpr_seq_t;

   // One management register word
   typedef logic [15:0] aenpr_word_t;

endpackage : aenpr_pkg

`default_nettype wire

/* File: aenpr_latch_high.sv */
`default_nettype none

module aenpr_latch_high
   import aenpr_pkg::*;
#(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] set,      // Event pulses, one per bit
   input  wire logic             clr,      // Read of the owning register
   output var  logic [WIDTH-1:0] flag_q    // Sticky flags
);

   logic [WIDTH-1:0] flag_d;  // Next flag values

   // Set wins over clear, so an event during the clearing read survives
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
         if (set[i]) begin
            flag_d[i] = 1'b1;
         end else if (clr) begin
            flag_d[i] = 1'b0;
         end else begin
            flag_d[i] = flag_q[i];
         end
      end
   end

   // Register only; clock enable freezes the flags
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= '0;
      end else if (ce) begin
         flag_q <= flag_d;
      end
   end

endmodule // aenpr_latch_high

`default_nettype wire

/* File: aenpr_toggle.sv */
`default_nettype none

module aenpr_toggle
   import aenpr_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic seed,        // Base word goes out
   input  wire logic seed_bit11,  // Bit 11 of that base word
   input  wire logic advance,     // A next-page word was sent
   output var  logic toggle_q     // Toggle for the coming next page
);

   logic toggle_d;  // Next toggle value

   // Seed with the inverse of base bit 11, then flip per sent word
   always_comb begin
      if (seed) begin
         toggle_d = ~seed_bit11;
      end else if (advance) begin
         toggle_d = ~toggle_q;
      end else begin
         toggle_d = toggle_q;
      end
   end

   // Register only
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         toggle_q <= 1'b0;
      end else if (ce) begin
         toggle_q <= toggle_d;
      end
   end

endmodule // aenpr_toggle

`default_nettype wire

/* File: aenpr_regs.sv */
`include "aenpr_map.svh"
`default_nettype none

module aenpr_regs
   import aenpr_pkg::*;
#(
   parameter int unsigned ADDR_W = 5,   // Management register address width
   parameter int unsigned CW_W   = 11   // Override-writable reserved bits
) (
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire logic              ce,
   // Decoded management access
   input  wire logic [ADDR_W-1:0] mgmt_addr,
   input  wire logic              mgmt_wr,
   input  wire logic              mgmt_rd,
   input  wire logic [15:0]       mgmt_wdata,
   input  wire logic              override_writable,
   output var  logic [15:0]       mgmt_rdata,
   output var  logic              mgmt_rvalid,
   // Arbitration side, same clock
   input  wire logic              an_restart,
   input  wire logic              flp_burst_valid,
   input  wire logic              pd_fault_event,
   input  wire logic              rx_page_stored,
   input  wire logic              rx_page_is_base,
   input  wire logic              rx_next_page_flag,
   input  wire logic              base_tx_start,
   input  wire logic              base_bit11,
   input  wire logic              lcw_tx_done,
   output var  logic [15:0]       np_tx_word,
   output var  logic              np_tx_active,
   output var  logic [CW_W-1:0]   cw_aux_bits
);

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   logic hit_exp;    // Access targets expansion status
   logic hit_nptx;   // Access targets next-page transmit
   logic rd_exp;     // Read of expansion status this cycle

   always_comb begin
      hit_exp  = (mgmt_addr == ADDR_W'(`AENPR_OFF_EXP));
      hit_nptx = (mgmt_addr == ADDR_W'(`AENPR_OFF_NPTX));
      rd_exp   = mgmt_rd & hit_exp;
   end

   // ------------------------------------------------------------------
   // Latching-high status flags
   // ------------------------------------------------------------------
   logic [1:0] lh_set;   // Bit 0 page received, bit 1 parallel fault
   logic [1:0] lh_q;     // Latched flags

   always_comb begin
      lh_set[0] = rx_page_stored;
      lh_set[1] = pd_fault_event;
   end

   // Any read of the expansion register clears both latches, except a bit set by an event in that cycle
   aenpr_latch_high #(
      .WIDTH (2)
   ) u_latch (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .set     (lh_set),
      .clr     (rd_exp),
      .flag_q  (lh_q)
   );

   // ------------------------------------------------------------------
   // Partner ability status
   // ------------------------------------------------------------------
   logic lp_np_q;    // Partner next-page able
   logic lp_np_d;
   logic lp_an_q;    // Partner can auto-negotiate
   logic lp_an_d;

   // Restart wipes partner knowledge; a new exchange must rebuild it
   always_comb begin
      lp_np_d = lp_np_q;
      lp_an_d = lp_an_q;
      if (an_restart) begin
         lp_np_d = 1'b0;
         lp_an_d = 1'b0;
      end else begin
         // Only the base word says whether the partner does next pages
         if (rx_page_stored && rx_page_is_base) begin
            lp_np_d = rx_next_page_flag;
         end
         // Held once set, until restart
         if (flp_burst_valid) begin
            lp_an_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lp_np_q <= 1'b0;
         lp_an_q <= 1'b0;
      end else if (ce) begin
         lp_np_q <= lp_np_d;
         lp_an_q <= lp_an_d;
      end
   end

   // ------------------------------------------------------------------
   // Writable register state
   // ------------------------------------------------------------------
   logic             np_q;       // Continuation flag
   logic             np_d;
   logic             mp_q;       // Message page flag
   logic             mp_d;
   logic             second_acknowledge_q;     // Second acknowledge
   logic             second_acknowledge_d;
   logic [10:0]      code_q;     // Message or unformatted code
   logic [10:0]      code_d;
   logic [CW_W-1:0]  cw_q;       // Reserved override-writable shadow
   logic [CW_W-1:0]  cw_d;
   // Transmit register reset image, a true constant: the async reset
   // branch below must load literals, never a net driven by logic
   localparam aenpr_word_t NPTX_RST = `AENPR_NPTX_RST;

   // Writes; reserved and read-only positions of the transmit word drop
   always_comb begin
      np_d   = np_q;
      mp_d   = mp_q;
      second_acknowledge_d = second_acknowledge_q;
      code_d = code_q;
      cw_d   = cw_q;
      if (mgmt_wr && hit_nptx) begin
         np_d   = mgmt_wdata[`AENPR_NP_NEXT];
         mp_d   = mgmt_wdata[`AENPR_NP_MSGPG];
         second_acknowledge_d = mgmt_wdata[`AENPR_NP_SECOND_ACKNOWLEDGE];
         code_d = mgmt_wdata[`AENPR_NP_CODE_HI:`AENPR_NP_CODE_LO];
      end
      // Guards auxiliary functions against stray writes
      if (mgmt_wr && hit_exp && override_writable) begin
         cw_d = mgmt_wdata[`AENPR_EXP_CW_HI:`AENPR_EXP_CW_LO];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         np_q   <= NPTX_RST[`AENPR_NP_NEXT];
         mp_q   <= NPTX_RST[`AENPR_NP_MSGPG];
         second_acknowledge_q <= NPTX_RST[`AENPR_NP_SECOND_ACKNOWLEDGE];
         code_q <= NPTX_RST[`AENPR_NP_CODE_HI:`AENPR_NP_CODE_LO];
         cw_q   <= `AENPR_CW_RST;
      end else if (ce) begin
         np_q   <= np_d;
         mp_q   <= mp_d;
         second_acknowledge_q <= second_acknowledge_d;
         code_q <= code_d;
         cw_q   <= cw_d;
      end
   end

   // ------------------------------------------------------------------
   // Next-page exchange sequencing
   // ------------------------------------------------------------------
   aenpr_seq_t seq_q;      // Exchange phase
   aenpr_seq_t seq_d;
   logic       tgl_adv;    // A next page just left
   logic       toggle;     // Toggle for the coming next page

   always_comb begin
      seq_d = seq_q;
      unique case (seq_q)
         SEQ_IDLE: begin
            if (base_tx_start) begin
               seq_d = SEQ_BASE;
            end
         end
         SEQ_BASE: begin
            // Go on only if both ends want next pages
            if (lcw_tx_done) begin
               if (np_q && lp_np_q) begin
                  seq_d = SEQ_NEXT;
               end else begin
                  seq_d = SEQ_DONE;
               end
            end
         end
         SEQ_NEXT: begin
            // A page sent with the flag clear was the last one
            if (lcw_tx_done && !np_q) begin
               seq_d = SEQ_DONE;
            end
         end
         SEQ_DONE: begin
            seq_d = SEQ_DONE;
         end
         default: begin
            seq_d = SEQ_IDLE;
         end
      endcase
      if (an_restart) begin
         seq_d = SEQ_IDLE;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         seq_q <= SEQ_IDLE;
      end else if (ce) begin
         seq_q <= seq_d;
      end
   end

   always_comb begin
      tgl_adv = (seq_q == SEQ_NEXT) && lcw_tx_done;
   end

   aenpr_toggle u_toggle (
      .clk_sys    (clk_sys),
      .arst_n     (arst_n),
      .ce         (ce),
      .seed       (base_tx_start),
      .seed_bit11 (base_bit11),
      .advance    (tgl_adv),
      .toggle_q   (toggle)
   );

   // ------------------------------------------------------------------
   // Read images and registered outputs
   // ------------------------------------------------------------------
   aenpr_word_t exp_img;    // Expansion status as read
   aenpr_word_t nptx_img;   // Transmit word as read and sent
   aenpr_word_t rdata_d;
   logic        rvalid_d;
   aenpr_word_t word_d;
   logic        active_d;

   always_comb begin
      exp_img                        = '0;   // reserved stay zero
      exp_img[`AENPR_EXP_PDFLT]      = lh_q[1];
      exp_img[`AENPR_EXP_LPNP]       = lp_np_q;
      exp_img[`AENPR_EXP_NPABLE]     = `AENPR_NPABLE_VAL;
      exp_img[`AENPR_EXP_PGRX]       = lh_q[0];
      exp_img[`AENPR_EXP_LPAN]       = lp_an_q;
      nptx_img                       = '0;   // Reserved bit reads zero
      nptx_img[`AENPR_NP_NEXT]       = np_q;
      nptx_img[`AENPR_NP_MSGPG]      = mp_q;
      nptx_img[`AENPR_NP_SECOND_ACKNOWLEDGE]       = second_acknowledge_q;
      nptx_img[`AENPR_NP_TOGGLE]     = toggle;
      nptx_img[`AENPR_NP_CODE_HI:`AENPR_NP_CODE_LO] = code_q;
   end

   // Other addresses belong elsewhere: no valid, data zero
   always_comb begin
      rdata_d  = '0;
      rvalid_d = 1'b0;
      if (mgmt_rd && hit_exp) begin
         rdata_d  = exp_img;
         rvalid_d = 1'b1;
      end else if (mgmt_rd && hit_nptx) begin
         rdata_d  = nptx_img;
         rvalid_d = 1'b1;
      end
      word_d   = nptx_img;
      active_d = (seq_d == SEQ_NEXT);
   end

   // Outputs straight from flops; costs one cycle of latency
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mgmt_rdata   <= '0;
         mgmt_rvalid  <= 1'b0;
         np_tx_word   <= `AENPR_NPTX_RST;
         np_tx_active <= 1'b0;
         cw_aux_bits  <= `AENPR_CW_RST;
      end else if (ce) begin
         mgmt_rdata   <= rdata_d;
         mgmt_rvalid  <= rvalid_d;
         np_tx_word   <= word_d;
         np_tx_active <= active_d;
         cw_aux_bits  <= cw_d;
      end
   end

endmodule // aenpr_regs

`default_nettype wire

/* File: aenpr_regs_chk_assertions.sv */
`default_nettype none

module aenpr_regs_chk
   import aenpr_pkg::*;
#(
   parameter int unsigned ADDR_W = 5,
   parameter int unsigned CW_W   = 11
) (
   input wire logic              clk_sys,
   input wire logic              arst_n,
   input wire logic              ce,
   input wire logic [ADDR_W-1:0] mgmt_addr,
   input wire logic              mgmt_wr,
   input wire logic              mgmt_rd,
   input wire logic [15:0]       mgmt_wdata,
   input wire logic              override_writable,
   input wire logic [15:0]       mgmt_rdata,
   input wire logic              mgmt_rvalid,
   input wire logic              pd_fault_event,
   input wire logic              rx_page_stored,
   input wire logic              base_tx_start,
   input wire logic              base_bit11,
   input wire logic              lcw_tx_done,
   input wire logic [15:0]       np_tx_word,
   input wire logic              np_tx_active,
   input wire logic [CW_W-1:0]   cw_aux_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd6; // Taken read of the expansion register
   logic wr6; // Taken write of the expansion register
   logic wr7; // Taken write of the transmit register
   assign rd6 = ce && mgmt_rd && (mgmt_addr == 5'h06);
   assign wr6 = ce && mgmt_wr && (mgmt_addr == 5'h06);
   assign wr7 = ce && mgmt_wr && (mgmt_addr == 5'h07);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // Events taken since the last expansion read: bit 1 fault, bit 0 page.
   // Reads are spaced apart by the station, so track state, not adjacency.
   logic [1:0] lh_pend;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lh_pend <= 2'h0;
      end else if (ce) begin
         lh_pend <= {pd_fault_event, rx_page_stored} | (lh_pend & {2{!rd6}});
      end
   end

   chk_rsv_read_zero: assert property (rd6 |=> mgmt_rvalid && mgmt_rdata[15:5] == 11'h000)
      else $error("reserved expansion bits not zero");
   chk_np_able_one: assert property (rd6 |=> mgmt_rdata[2])
      else $error("local next page able bit low");
   chk_cw_isolated: assert property (wr6 && !override_writable |=> $stable(cw_aux_bits))
      else $error("reserved bits took a blocked write");
   chk_cw_accept: assert property (
      wr6 && override_writable |=> cw_aux_bits == $past(mgmt_wdata[15:5]))
      else $error("reserved bits ignored an enabled write");
   chk_pd_latched: assert property (rd6 && lh_pend[1] |=> mgmt_rdata[4])
      else $error("parallel fault not latched");
   chk_latch_clear: assert property (rd6 |=>
      {mgmt_rdata[4], mgmt_rdata[1]} == $past(lh_pend))
      else $error("latched bits survived a read");
   chk_word_follow: assert property (
      wr7 ##1 (ce && !mgmt_wr) |=>
         np_tx_word[15] == $past(mgmt_wdata[15], 2) &&
         np_tx_word[13:12] == $past(mgmt_wdata[13:12], 2) &&
         np_tx_word[10:0] == $past(mgmt_wdata[10:0], 2) &&
         !np_tx_word[14])
      else $error("transmit word does not follow register");
   chk_toggle_seed: assert property (
      ce && base_tx_start ##1 (ce && !lcw_tx_done) |=>
         np_tx_word[11] == !$past(base_bit11, 2))
      else $error("toggle not seeded from base bit");
   chk_phase_cause: assert property ($rose(np_tx_active) |-> $past(lcw_tx_done))
      else $error("next page phase began without a sent word");

   cov_read_exp: cover property (rd6 ##1 mgmt_rvalid);
   cov_phase: cover property ($rose(np_tx_active));
   cov_cw_write: cover property (wr6 && override_writable);
endmodule // aenpr_regs_chk

bind aenpr_regs aenpr_regs_chk #(.ADDR_W(ADDR_W), .CW_W(CW_W)) i_chk (.clk_sys, .arst_n, .ce,
   .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .override_writable, .mgmt_rdata, .mgmt_rvalid,
   .pd_fault_event, .rx_page_stored, .base_tx_start, .base_bit11, .lcw_tx_done, .np_tx_word,
   .np_tx_active, .cw_aux_bits);

`default_nettype wire

/* File: aenpr_sta_model.sv */
`default_nettype none

// Management station: one-cycle strobes, read data taken one cycle later
module aenpr_sta_model (
   input  wire logic        clk_sys,
   output var  logic [4:0]  mgmt_addr,
   output var  logic        mgmt_wr,
   output var  logic        mgmt_rd,
   output var  logic [15:0] mgmt_wdata,
   input  wire logic [15:0] mgmt_rdata,
   input  wire logic        mgmt_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      mgmt_addr  = 5'h00;
      mgmt_wr    = 1'b0;
      mgmt_rd    = 1'b0;
      mgmt_wdata = 16'h0000;
   end

   // Reserved bit 14 of the transmit register is always sent at its default
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      mgmt_addr  <= a;
      mgmt_wdata <= (a == 5'h07) ? (d & 16'hBFFF) : d;
      mgmt_wr    <= 1'b1;
      @(posedge clk_sys);
      mgmt_wr    <= 1'b0;
      mgmt_wdata <= ~d; // Stale data never mirrors the last word
   endtask

   // A missing answer hands back unknowns so the compare fails
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      mgmt_addr <= a;
      mgmt_rd   <= 1'b1;
      @(posedge clk_sys);
      mgmt_rd   <= 1'b0;
      // The answer stands for this cycle; take it mid-cycle, clear of the edge
      @(negedge clk_sys);
      d = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 16'hXXXX;
      @(posedge clk_sys);
   endtask
endmodule // aenpr_sta_model

`default_nettype wire

/* File: aenpr_regs_tb.sv */
`default_nettype none

module aenpr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys;           // 200 MHz system clock
   logic        arst_n;            // Reset, active low
   logic        ce;                // Clock enable
   logic [4:0]  mgmt_addr;         // Station request
   logic        mgmt_wr;
   logic        mgmt_rd;
   logic [15:0] mgmt_wdata;
   logic [15:0] mgmt_rdata;        // Answer
   logic        mgmt_rvalid;
   logic        override_writable; // Override control level
   logic [6:0]  ev;                // Link-side event pulses
   logic        base_bit11;        // Bit 11 of the base word
   logic        rx_page_is_base;   // Qualifies stored word
   logic [15:0] np_tx_word;
   logic        np_tx_active;
   logic [10:0] cw_aux_bits;
   logic [15:0] v;                 // Last read value
   int          fail_count;
   int          comparisons;

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   aenpr_sta_model i_sta (.clk_sys(clk_sys), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
      .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
      .mgmt_rvalid(mgmt_rvalid));

   aenpr_regs i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .mgmt_addr(mgmt_addr),
      .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
      .override_writable(override_writable), .mgmt_rdata(mgmt_rdata),
      .mgmt_rvalid(mgmt_rvalid), .an_restart(ev[0]), .flp_burst_valid(ev[1]),
      .pd_fault_event(ev[2]), .rx_page_stored(ev[3]), .rx_page_is_base(rx_page_is_base),
      .rx_next_page_flag(ev[4]), .base_tx_start(ev[5]), .base_bit11(base_bit11),
      .lcw_tx_done(ev[6]), .np_tx_word(np_tx_word), .np_tx_active(np_tx_active),
      .cw_aux_bits(cw_aux_bits));

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Pulse a set of events for one cycle, then let status settle
   task automatic pulse(input logic [6:0] m);
      @(posedge clk_sys);
      ev <= m;
      @(posedge clk_sys);
      ev <= 7'h00;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic end_of_test;
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard at 4000 cycles: the tests need well under 500 cycles
   initial begin
      #20000;
      fail_count++;
      end_of_test();
   end

   initial begin
      fail_count = 0;
      comparisons = 0;
      arst_n = 1'b0;
      ce = 1'b1;
      override_writable = 1'b0;
      ev = 7'h00;
      base_bit11 = 1'b0;
      rx_page_is_base = 1'b1;
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk(np_tx_word, 16'h2001);
      i_sta.rd(5'h06, v); chk(v, 16'h0004);
      i_sta.rd(5'h07, v); chk(v, 16'h2001);
      i_sta.rd(5'h05, v); chk(v, 16'hXXXX); // Unmapped: no answer expected
      // Blocked, then accepted reserved writes; reads stay zero
      i_sta.wr(5'h06, 16'hFFE0);
      @(posedge clk_sys); chk({5'h00, cw_aux_bits}, 16'h0000);
      override_writable <= 1'b1;
      i_sta.wr(5'h06, 16'hFFE0);
      @(posedge clk_sys); chk({5'h00, cw_aux_bits}, 16'h07FF);
      i_sta.rd(5'h06, v); chk(v, 16'h0004);
      i_sta.wr(5'h06, 16'h0000);
      override_writable <= 1'b0;
      // Partner status and latched flags
      pulse(7'h02);
      i_sta.rd(5'h06, v); chk(v, 16'h0005);
      pulse(7'h04);
      i_sta.rd(5'h06, v); chk(v, 16'h0015);
      i_sta.rd(5'h06, v); chk(v, 16'h0005);
      // A fault pulse while the clock enable is low must not be taken
      ce <= 1'b0;
      pulse(7'h04);
      ce <= 1'b1;
      i_sta.rd(5'h06, v); chk(v, 16'h0005);
      pulse(7'h18);
      i_sta.rd(5'h06, v); chk(v, 16'h000F);
      i_sta.rd(5'h06, v); chk(v, 16'h000D);
      // Transmit word: toggle bit is read-only
      i_sta.wr(5'h07, 16'hBFFF);
      i_sta.rd(5'h07, v); chk(v, 16'hB7FF);
      chk(np_tx_word, 16'hB7FF);
      base_bit11 <= 1'b1;
      pulse(7'h20);
      chk(np_tx_word, 16'hB7FF);
      pulse(7'h40);
      chk({15'h0000, np_tx_active}, 16'h0001);
      pulse(7'h40);
      chk(np_tx_word, 16'hBFFF);
      i_sta.wr(5'h07, 16'h2001);
      repeat (2) @(posedge clk_sys); chk(np_tx_word, 16'h2801);
      pulse(7'h40);
      chk({np_tx_word[15:1], np_tx_active}, 16'h2000);
      // After restart the partner no longer offers next pages
      pulse(7'h01);
      i_sta.rd(5'h06, v); chk(v, 16'h0004);
      i_sta.wr(5'h07, 16'h8001);
      base_bit11 <= 1'b0;
      pulse(7'h20);
      chk(np_tx_word, 16'h8801);
      pulse(7'h40);
      chk({15'h0000, np_tx_active}, 16'h0000);
      end_of_test();
   end
endmodule // aenpr_regs_tb

`default_nettype wire
